// file: logic/sbc_wd_bus_wake_ctrl.sv
// watchdog, transceiver mode, peak threshold and timer wake control registers
// What this block does
// - failure still drives outputs after software enable cleared
// - restart clears software failure enable, outputs off unless failure flag set
// - watchdog bit 6 disables watchdog in stop
// - wake bit 2 disables watchdog in stop
// - watchdog bit 5 selects time-out or window
// - watchdog bit 4 starts watchdog after bus wake
// - watchdog bits 2:0 select period, 111 reserved
// - watchdog resets 0x14; restart loads low nibble 4
// - bus bits 1:0 select transceiver mode
// - fail-safe reloads wake-capable transceiver mode
// - transceiver register zero; restart takes cause mode
// - bit 5 selects low or high peak threshold
// - peak bit writable only in init or normal
// - stop-mode peak write ignored unless init mode is set, no error, no interrupt
// - wake bits 7, 6 enable cyclic timer wakes
// - reserved bits read zero, ignore writes
// - wake register zero; restart keeps timer enables
// - peak register zero; restart keeps peak bit
// - mode 10 is stop, 11 soft reset
// - global flag lets all status raise interrupt
`timescale 1ns/1ps
`include "sbc_wd_map.svh"

module sbc_wd_bus_wake_ctrl (
  // system clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // serial register link
  input wire logic link_sclk_i,
  input wire logic link_csn_i,
  input wire logic link_mosi_i,
  output logic link_miso_o,
  output logic link_miso_oe_n_o,
  // device state
  input wire logic [1:0] mode_i,
  input wire logic init_mode_i,
  input wire logic restart_entry_i,
  input wire logic failsafe_entry_i,
  input wire sbc_wd_pkg::xcvr_mode_e restart_xcvr_mode_i,
  input wire sbc_wd_pkg::hw_upd_s hw_upd_i,
  // failure and interrupt sources
  input wire logic failure_flag_i,
  input wire logic int_global_i,
  input wire logic wake_event_i,
  input wire logic status_event_i,
  // configuration and status
  output sbc_wd_pkg::cfg_s cfg_o,
  output logic failure_outputs_o,
  output logic write_error_o,
  output logic int_req_o
);

  // link domain
  logic link_rst_n;
  logic [3:0] bit_cnt_q;
  logic [14:0] shift_in_q;
  logic [14:0] shift_out_q;
  logic [15:0] frame_q;
  logic frame_tgl_q;
  logic miso_q;

  // system domain
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  logic csn_s1_q;
  logic csn_s2_q;
  logic miso_oe_n_q;
  logic [7:0] rd_word_q;
  logic [7:0] wd_q;
  logic [7:0] xcvr_q;
  logic [7:0] peak_q;
  logic [7:0] iwk_q;
  logic fo_en_q;
  logic fo_out_q;
  logic wr_err_q;
  logic int_q;

  logic frm_evt;
  logic wr_evt;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic is_stop;
  logic is_soft;
  logic is_normal;
  logic peak_wr_ok;
  logic wr_unmapped;

  // register image seen by a read; reserved bits are already zero in storage
  function automatic logic [7:0] reg_read(input logic [6:0] addr, input logic [7:0] wd,
                                          input logic [7:0] xc, input logic [7:0] pk,
                                          input logic [7:0] iw, input logic fo);
    logic [7:0] val;
    val = 8'h00;
    unique case (addr)
      `ADDR_HW_CTRL: val = {2'h0, fo, 5'h00};
      `ADDR_WD: val = wd;
      `ADDR_XCVR: val = xc;
      `ADDR_PEAK: val = pk;
      `ADDR_IWK: val = iw;
      default: val = 8'h00;
    endcase
    return val;
  endfunction

  function automatic logic reg_hit(input logic [6:0] addr, input logic [6:0] target);
    return addr == target;
  endfunction

  // link domain
  // chip select high clears the bit position, so each frame starts aligned
  assign link_rst_n = reset_n_i & ~link_csn_i;

  always_ff @(posedge link_sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_q <= 4'h0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge link_sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shift_in_q <= 15'h0000;
    end else begin
      shift_in_q <= {shift_in_q[13:0], link_mosi_i};
    end
  end

  // word and toggle survive chip select; only the system reset clears them
  always_ff @(posedge link_sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_q <= 16'h0000;
      frame_tgl_q <= 1'b0;
    end else if (bit_cnt_q == 4'hf) begin
      frame_q <= {shift_in_q, link_mosi_i};
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  // rd_word_q only changes after the previous frame ends, so it is quiet here
  always_ff @(posedge link_sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      miso_q <= 1'b0;
      shift_out_q <= 15'h0000;
    end else if (bit_cnt_q == 4'h0) begin
      miso_q <= 1'b0;
      shift_out_q <= {7'h00, rd_word_q};
    end else begin
      miso_q <= shift_out_q[14];
      shift_out_q <= {shift_out_q[13:0], 1'b0};
    end
  end

  assign link_miso_o = miso_q;

  // crossing into system domain
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      tgl_s1_q <= frame_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      csn_s1_q <= 1'b1;
      csn_s2_q <= 1'b1;
      miso_oe_n_q <= 1'b1;
    end else begin
      csn_s1_q <= link_csn_i;
      csn_s2_q <= csn_s1_q;
      miso_oe_n_q <= csn_s2_q;
    end
  end

  assign link_miso_oe_n_o = miso_oe_n_q;

  // frame_q has been stable for two system edges once the toggle is seen
  assign frm_evt = tgl_s2_q ^ tgl_s3_q;
  assign wr_evt = frm_evt & frame_q[`FRAME_WR_BIT];
  assign wr_addr = frame_q[14:8];
  assign wr_data = frame_q[7:0];

  assign is_stop = mode_i == `MODE_STOP;
  assign is_soft = mode_i == `MODE_SOFT_RST;
  assign is_normal = mode_i == `MODE_NORMAL;
  assign peak_wr_ok = init_mode_i | is_normal;

  assign wr_unmapped = wr_evt & ~reg_hit(wr_addr, `ADDR_HW_CTRL) & ~reg_hit(wr_addr, `ADDR_WD)
                       & ~reg_hit(wr_addr, `ADDR_XCVR) & ~reg_hit(wr_addr, `ADDR_PEAK)
                       & ~reg_hit(wr_addr, `ADDR_IWK);

  // answer of a frame is the addressed register before its own write
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_word_q <= 8'h00;
    end else if (frm_evt) begin
      rd_word_q <= reg_read(wr_addr, wd_q, xcvr_q, peak_q, iwk_q, fo_en_q);
    end
  end

  // registers
  // priority: soft reset, restart, hardware update, host write
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wd_q <= `WD_RST;
    end else if (is_soft) begin
      wd_q <= `WD_RST;
    end else if (restart_entry_i) begin
      wd_q <= {wd_q[7], 1'b0, wd_q[5:4], `WD_RESTART_LO};
    end else begin
      if (wr_evt && reg_hit(wr_addr, `ADDR_WD)) begin
        // parity bit stored as sent; checking it belongs to the watchdog engine
        wd_q <= wr_data & `WD_MASK;
      end
      if (hw_upd_i.stop_dis_we) begin
        wd_q[`WD_STOP_A_BIT] <= hw_upd_i.stop_dis;
      end
      if (hw_upd_i.period_we) begin
        wd_q[`WD_PERIOD_HI:0] <= hw_upd_i.period;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xcvr_q <= `XCVR_RST;
    end else if (is_soft) begin
      xcvr_q <= `XCVR_RST;
    end else if (restart_entry_i) begin
      xcvr_q <= {6'h00, restart_xcvr_mode_i};
    end else if (failsafe_entry_i) begin
      xcvr_q <= {6'h00, `FS_XCVR_MODE};
    end else if (hw_upd_i.xcvr_we) begin
      xcvr_q <= {6'h00, hw_upd_i.xcvr_mode};
    end else if (wr_evt && reg_hit(wr_addr, `ADDR_XCVR)) begin
      xcvr_q <= wr_data & `XCVR_MASK;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      peak_q <= `PEAK_RST;
    end else if (is_soft) begin
      peak_q <= `PEAK_RST;
    end else if (restart_entry_i) begin
      peak_q <= peak_q & `PEAK_MASK;
    end else if (wr_evt && reg_hit(wr_addr, `ADDR_PEAK) && peak_wr_ok) begin
      peak_q <= wr_data & `PEAK_MASK;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      iwk_q <= `IWK_RST;
    end else if (is_soft) begin
      iwk_q <= `IWK_RST;
    end else if (restart_entry_i) begin
      iwk_q <= {iwk_q[7:6], 6'h00};
    end else begin
      if (wr_evt && reg_hit(wr_addr, `ADDR_IWK)) begin
        iwk_q <= wr_data & `IWK_MASK;
      end
      if (hw_upd_i.stop_dis_we) begin
        iwk_q[`IWK_STOP_B_BIT] <= hw_upd_i.stop_dis;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fo_en_q <= 1'b0;
    end else if (is_soft || restart_entry_i) begin
      fo_en_q <= 1'b0;
    end else if (wr_evt && reg_hit(wr_addr, `ADDR_HW_CTRL)) begin
      fo_en_q <= wr_data[`FO_BIT];
    end
  end

  // the failure flag keeps the outputs on whatever software does to its enable
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fo_out_q <= 1'b0;
    end else begin
      fo_out_q <= (fo_en_q & ~restart_entry_i & ~is_soft) | failure_flag_i;
    end
  end

  assign failure_outputs_o = fo_out_q;

  // a refused peak write in stop mode is silent by design
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_err_q <= 1'b0;
    end else begin
      wr_err_q <= wr_unmapped;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      int_q <= 1'b0;
    end else begin
      int_q <= wake_event_i | (int_global_i & (status_event_i | wr_unmapped));
    end
  end

  assign write_error_o = wr_err_q;
  assign int_req_o = int_q;

  assign cfg_o = '{
    chk: wd_q[`WD_CHK_BIT],
    stop_dis_a: wd_q[`WD_STOP_A_BIT],
    type_window: wd_q[`WD_TYPE_BIT],
    start_on_bus_wake: wd_q[`WD_BUS_WAKE_BIT],
    period: wd_q[`WD_PERIOD_HI:0],
    xcvr_mode: sbc_wd_pkg::xcvr_mode_e'(xcvr_q[1:0]),
    peak_high: peak_q[`PEAK_BIT],
    timer_b_wake_en: iwk_q[`IWK_TMR_B_BIT],
    timer_a_wake_en: iwk_q[`IWK_TMR_A_BIT],
    stop_dis_b: iwk_q[`IWK_STOP_B_BIT]
  };

  // checks
  default clocking chk_clk @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence quiet_s;
    !is_soft && !restart_entry_i;
  endsequence

  sequence wd_write_s;
    wr_evt && reg_hit(wr_addr, `ADDR_WD) && !hw_upd_i.stop_dis_we && !hw_upd_i.period_we;
  endsequence

  sequence peak_write_s;
    wr_evt && reg_hit(wr_addr, `ADDR_PEAK);
  endsequence

  wd_write_store_a: assert property (quiet_s and wd_write_s |=> wd_q == ($past(wr_data) & 8'hf7))
    else $error("watchdog write not stored");

  wd_restart_a: assert property (restart_entry_i && !is_soft |=> wd_q[3:0] == 4'h4
      && !wd_q[6] && wd_q[7] == $past(wd_q[7]) && wd_q[5:4] == $past(wd_q[5:4]))
    else $error("watchdog restart value wrong");

  soft_reset_a: assert property (is_soft |=> wd_q == 8'h14 && xcvr_q == 8'h00
      && peak_q == 8'h00 && iwk_q == 8'h00 && !fo_en_q)
    else $error("soft reset values wrong");

  fo_failure_a: assert property (failure_flag_i |=> failure_outputs_o)
    else $error("failure did not hold outputs");

  fo_restart_a: assert property (restart_entry_i ##1 !failure_flag_i[*2] |=> !failure_outputs_o)
    else $error("restart left outputs on");

  peak_stop_a: assert property (quiet_s and (is_stop && !init_mode_i) |=> $stable(peak_q))
    else $error("peak bit changed in stop mode");

  peak_write_a: assert property (quiet_s and peak_write_s and peak_wr_ok
      |=> peak_q[5] == $past(wr_data[5]))
    else $error("peak write in normal mode lost");

  peak_silent_a: assert property (peak_write_s ##0 is_stop ##0 !wake_event_i ##0 !status_event_i
      |=> !write_error_o && !int_req_o)
    else $error("stop-mode peak write flagged");

  failsafe_xcvr_a: assert property (quiet_s and failsafe_entry_i |=> xcvr_q == 8'h01)
    else $error("fail-safe transceiver mode wrong");

  iwk_restart_a: assert property (restart_entry_i && !is_soft
      |=> iwk_q[7:6] == $past(iwk_q[7:6]) && iwk_q[5:0] == 6'h00)
    else $error("wake register restart value wrong");

  reserved_zero_a: assert property ((wd_q & 8'h08) == 8'h00 && (xcvr_q & 8'hfc) == 8'h00
      && (peak_q & 8'hdf) == 8'h00 && (iwk_q & 8'h3b) == 8'h00)
    else $error("reserved bit set");

  wake_int_a: assert property (wake_event_i |=> int_req_o)
    else $error("wake did not raise interrupt");

  no_global_int_a: assert property (!wake_event_i && !int_global_i |=> !int_req_o)
    else $error("interrupt without wake source");

endmodule

// file: logic/sbc_wd_map.svh
// register offsets, field positions, reset values and masks of the control slice
`ifndef SBC_WD_MAP_SVH
`define SBC_WD_MAP_SVH

`define FRAME_BITS 16
`define FRAME_WR_BIT 15
`define ADDR_HW_CTRL 7'h02
`define ADDR_WD 7'h03
`define ADDR_XCVR 7'h04
`define ADDR_PEAK 7'h05
`define ADDR_IWK 7'h06

`define MODE_NORMAL 2'h0
`define MODE_STOP 2'h2
`define MODE_SOFT_RST 2'h3

`define WD_CHK_BIT 7
`define WD_STOP_A_BIT 6
`define WD_TYPE_BIT 5
`define WD_BUS_WAKE_BIT 4
`define WD_PERIOD_HI 2
`define FO_BIT 5
`define PEAK_BIT 5
`define IWK_TMR_B_BIT 7
`define IWK_TMR_A_BIT 6
`define IWK_STOP_B_BIT 2

`define WD_MASK 8'hf7
`define XCVR_MASK 8'h03
`define PEAK_MASK 8'h20
`define IWK_MASK 8'hc4
`define FO_MASK 8'h20

`define WD_RST 8'h14
`define XCVR_RST 8'h00
`define PEAK_RST 8'h00
`define IWK_RST 8'h00
`define WD_RESTART_LO 4'h4
`define FS_XCVR_MODE 2'h1

`endif

// file: logic/sbc_wd_pkg.sv
// types shared by the watchdog and bus wake control slice
package sbc_wd_pkg;

  typedef enum logic [1:0] {
    XCVR_OFF = 2'h0,
    XCVR_WAKE = 2'h1,
    XCVR_RX_ONLY = 2'h2,
    XCVR_NORMAL = 2'h3
  } xcvr_mode_e;

  typedef struct packed {
    logic chk;
    logic stop_dis_a;
    logic type_window;
    logic start_on_bus_wake;
    logic [2:0] period;
    xcvr_mode_e xcvr_mode;
    logic peak_high;
    logic timer_b_wake_en;
    logic timer_a_wake_en;
    logic stop_dis_b;
  } cfg_s;

  typedef struct packed {
    logic stop_dis_we;
    logic stop_dis;
    logic period_we;
    logic [2:0] period;
    logic xcvr_we;
    xcvr_mode_e xcvr_mode;
  } hw_upd_s;

endpackage

// file: testbench/sbc_host_model.sv
// host side serial master for the control register link
`timescale 1ns/1ps
module sbc_host_model (
  // serial link
  output logic link_sclk_o,
  output logic link_csn_o,
  output logic link_mosi_o,
  input wire logic link_miso_i,
  // captured answer word
  output logic [15:0] rx_word_o,
  output logic rx_stb_o
);
  initial begin
    link_sclk_o = 1'b0;
    link_csn_o = 1'b1;
    link_mosi_o = 1'b0;
    rx_word_o = 16'h0000;
    rx_stb_o = 1'b0;
  end

  // clock stands low between frames; mosi flips so stale data never looks valid
  task automatic frame(inout logic [15:0] w);
    logic [15:0] r;
    r = 16'h0000;
    if (w[15] && w[14:8] == 7'h03) begin
      w[7] = ^w[6:0];
    end
    link_csn_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      link_mosi_o = w[i];
      #80 link_sclk_o = 1'b1;
      #75 r = {r[14:0], link_miso_i};
      #5 link_sclk_o = 1'b0;
    end
    link_csn_o = 1'b1;
    link_mosi_o = ~link_mosi_o;
    rx_word_o = r;
    rx_stb_o = 1'b1;
    #1 rx_stb_o = 1'b0;
    // gap well above eight system cycles so the answer word settles
    #450;
  endtask
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the watchdog and bus wake control registers
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic link_sclk, link_csn, link_mosi, link_miso, link_miso_oe_n, miso_line;
  logic [1:0] mode_i = 2'h0;
  logic init_mode_i = 1'b0;
  logic restart_entry_i = 1'b0;
  logic failsafe_entry_i = 1'b0;
  sbc_wd_pkg::xcvr_mode_e restart_xcvr_mode_i = sbc_wd_pkg::XCVR_OFF;
  sbc_wd_pkg::hw_upd_s hw_upd_i = '0;
  logic failure_flag_i = 1'b0;
  logic int_global_i = 1'b0;
  logic wake_event_i = 1'b0;
  logic status_event_i = 1'b0;
  sbc_wd_pkg::cfg_s cfg_o;
  logic failure_outputs_o, write_error_o, int_req_o, rx_stb, rd_ok;
  logic [15:0] rx_word;
  int mismatches = 0, num_checks = 0, err_seen = 0, int_seen = 0, err_exp = 0, int_exp = 0;
  logic [7:0] sh [2:6];
  logic [7:0] prev_rd;
  logic [16:0] notes [$];
  logic [16:0] note;

  always #12.5 sys_clk_i = ~sys_clk_i;
  assign miso_line = link_miso_oe_n ? 1'bz : link_miso;

  sbc_wd_bus_wake_ctrl sbc_wd_bus_wake_ctrl_inst (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .link_sclk_i(link_sclk),
    .link_csn_i(link_csn), .link_mosi_i(link_mosi), .link_miso_o(link_miso),
    .link_miso_oe_n_o(link_miso_oe_n), .mode_i(mode_i), .init_mode_i(init_mode_i),
    .restart_entry_i(restart_entry_i), .failsafe_entry_i(failsafe_entry_i),
    .restart_xcvr_mode_i(restart_xcvr_mode_i), .hw_upd_i(hw_upd_i),
    .failure_flag_i(failure_flag_i), .int_global_i(int_global_i),
    .wake_event_i(wake_event_i), .status_event_i(status_event_i), .cfg_o(cfg_o),
    .failure_outputs_o(failure_outputs_o), .write_error_o(write_error_o),
    .int_req_o(int_req_o));

  sbc_host_model sbc_host_model_inst (
    .link_sclk_o(link_sclk), .link_csn_o(link_csn), .link_mosi_o(link_mosi),
    .link_miso_i(miso_line), .rx_word_o(rx_word), .rx_stb_o(rx_stb));

  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [7:0] mask(input logic [6:0] a);
    case (a)
      7'h03: return 8'hf7;
      7'h04: return 8'h03;
      7'h06: return 8'hc4;
      default: return 8'h20;
    endcase
  endfunction

  function automatic sbc_wd_pkg::cfg_s cfg_exp();
    return {sh[3][7:4], sh[3][2:0], sh[4][1:0], sh[5][5], sh[6][7], sh[6][6], sh[6][2]};
  endfunction

  // pulse counters; pulses stand one cycle, so sample them mid-cycle where settled
  always @(negedge sys_clk_i) begin
    if (write_error_o === 1'b1) err_seen++;
    if (int_req_o === 1'b1) int_seen++;
  end

  always @(posedge rx_stb) begin
    if (notes.size() == 0) chk(1'b0, "answer word without note");
    else begin
      note = notes.pop_front();
      if (note[16]) chk(rx_word === note[15:0], "answer word");
    end
  end

  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] w;
    w = {wr, a, d};
    notes.push_back({rd_ok, 8'h00, prev_rd});
    sbc_host_model_inst.frame(w);
    prev_rd = (a >= 7'h02 && a <= 7'h06) ? sh[a] : 8'h00;
    rd_ok = 1'b1;
    if (wr && a >= 7'h02 && a <= 7'h06) begin
      if (!(a == 7'h05 && mode_i != 2'h0 && !init_mode_i)) sh[a] = w[7:0] & mask(a);
    end else if (wr) begin
      err_exp++;
      if (int_global_i) int_exp++;
    end
    chk(cfg_o === cfg_exp(), "configuration fields");
    chk(link_miso_oe_n === 1'b1, "miso released between frames");
  endtask

  task automatic ev(input int k);
    @(negedge sys_clk_i);
    case (k)
      0: begin
        restart_entry_i = 1'b1;
        sh[2] = 8'h00;
        sh[3] = {sh[3][7], 1'b0, sh[3][5:4], 4'h4};
        sh[4] = {6'h00, restart_xcvr_mode_i};
        sh[5] = sh[5] & 8'h20;
        sh[6] = sh[6] & 8'hc0;
      end
      1: begin
        failsafe_entry_i = 1'b1;
        sh[4] = 8'h01;
      end
      2: begin
        wake_event_i = 1'b1;
        int_exp++;
      end
      3: begin
        status_event_i = 1'b1;
        if (int_global_i) int_exp++;
      end
      default: begin
        hw_upd_i = {3'h7, 3'h6, 1'b1, sbc_wd_pkg::XCVR_RX_ONLY};
        sh[3] = {sh[3][7], 1'b1, sh[3][5:3], 3'h6};
        sh[4] = 8'h02;
        sh[6][2] = 1'b1;
      end
    endcase
    @(negedge sys_clk_i);
    {restart_entry_i, failsafe_entry_i, wake_event_i, status_event_i} = 4'h0;
    hw_upd_i = '0;
    repeat (2) @(negedge sys_clk_i);
  endtask

  initial begin
    #1_000_000;
    mismatches++;
    summarize();
  end

  initial begin
    int unused;
    sh[2] = 8'h00;
    sh[3] = 8'h14;
    sh[4] = 8'h00;
    sh[5] = 8'h00;
    sh[6] = 8'h00;
    rd_ok = 1'b0;
    prev_rd = 8'h00;
    unused = $urandom(55);
    repeat (12) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    @(negedge sys_clk_i);
    chk(cfg_o === cfg_exp(), "reset values");
    for (int a = 2; a <= 8; a++) xfer(1'b0, a[6:0], 8'hff);
    $display("test reset and read-back done");
    for (int n = 0; n < 40; n++) begin
      @(negedge sys_clk_i);
      mode_i = ($urandom % 2) ? 2'h2 : 2'h0;
      init_mode_i = 1'($urandom);
      int_global_i = 1'($urandom);
      xfer(1'b1, 7'($urandom_range(7, 2)), 8'($urandom));
      xfer(1'b0, 7'($urandom_range(7, 2)), 8'h00);
    end
    $display("test random traffic done");
    @(negedge sys_clk_i);
    mode_i = 2'h0;
    ev(4);
    xfer(1'b1, 7'h02, 8'hff);
    chk(failure_outputs_o === 1'b1, "software failure output on");
    @(negedge sys_clk_i);
    restart_xcvr_mode_i = sbc_wd_pkg::xcvr_mode_e'($urandom_range(3, 0));
    ev(0);
    chk(failure_outputs_o === 1'b0, "restart drops failure outputs");
    chk(cfg_o === cfg_exp(), "restart values");
    xfer(1'b0, 7'h02, 8'h00);
    @(negedge sys_clk_i);
    failure_flag_i = 1'b1;
    xfer(1'b1, 7'h02, 8'h20);
    xfer(1'b1, 7'h02, 8'h00);
    chk(failure_outputs_o === 1'b1, "failure keeps outputs on");
    @(negedge sys_clk_i);
    failure_flag_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk(failure_outputs_o === 1'b0, "outputs released");
    $display("test restart and failure outputs done");
    ev(1);
    chk(cfg_o === cfg_exp(), "fail-safe wake mode");
    int_global_i = 1'b1;
    ev(3);
    ev(2);
    int_global_i = 1'b0;
    ev(3);
    mode_i = 2'h3;
    repeat (3) @(negedge sys_clk_i);
    mode_i = 2'h0;
    sh[2] = 8'h00;
    sh[3] = 8'h14;
    sh[4] = 8'h00;
    sh[5] = 8'h00;
    sh[6] = 8'h00;
    @(negedge sys_clk_i);
    chk(cfg_o === cfg_exp(), "soft reset values");
    xfer(1'b0, 7'h03, 8'h00);
    xfer(1'b0, 7'h06, 8'h00);
    chk(notes.size() == 0, "answer words outstanding");
    chk(err_seen == err_exp, "unmapped write errors");
    chk(int_seen == int_exp, "interrupt requests");
    $display("test fail-safe, interrupts and soft reset done");
    summarize();
  end
endmodule
